//--- core/mcx_pkg.sv
/*
  Shared constants and types for the muting configuration check and lamp block.
  Assumes one system clock and a synchronous active-low reset around it.
*/
package mcx_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] MCX_OFF_STATUS = 5'h00;
  localparam logic [4:0] MCX_OFF_MASK   = 5'h04;
  localparam logic [4:0] MCX_OFF_CFG    = 5'h08;
  localparam logic [4:0] MCX_OFF_LIVE   = 5'h0c;
  localparam logic [4:0] MCX_OFF_CTRL   = 5'h10;

  // Status bit positions, the mask uses the same layout
  localparam int MCX_ST_CHANGE = 0;
  localparam int MCX_ST_BANK   = 1;
  localparam int MCX_ST_MODE   = 2;
  localparam int MCX_ST_W      = 3;

  // Control bit: write one to ask for a fault release
  localparam int MCX_CTRL_CLR  = 0;

  // Reset values
  localparam logic [MCX_ST_W-1:0] MCX_STATUS_RST = 3'h0;
  localparam logic [MCX_ST_W-1:0] MCX_MASK_RST   = 3'h0;
  localparam logic [7:0]          MCX_SNAP_RST   = 8'h00;
  localparam logic [6:0]          MCX_SEG_BLANK  = 7'h00;

  // Switch pattern of the one permitted operating mode, switches 1..6
  localparam logic [5:0] MCX_MODE7_PAT = 6'h18;
  localparam logic [3:0] MCX_DIGIT_MODE7 = 4'h7;
  localparam logic [3:0] MCX_DIGIT_ERR   = 4'he;

  // One bank of switches; switch 1 sits in the lowest bit
  typedef struct packed {
    logic [1:0] timeout_sel;     // Switches 7/8
    logic       timeout_ext;     // Switch 6
    logic       mute_en_used;    // Switch 5
    logic       restart_manual;  // Switch 4
    logic       feedback_check;  // Switch 3, contactor_feedback_check
    logic       seq_mode;        // Switch 2
    logic       four_sensor;     // Switch 1
  } mcx_cfg_t;

  // Error conditions seen in one cycle
  typedef struct packed {
    logic mode;
    logic bank;
    logic change;
  } mcx_err_t;

endpackage

//--- core/mcx_seg_decode.sv
/*
  Seven-segment decoder for one hex digit, segments a..g in bits 0..6.
  Purely combinational; the caller registers the result.
*/
module mcx_seg_decode (
  input  wire logic [3:0] digit_i,
  output logic      [6:0] seg_o
);
  import mcx_pkg::*;

  // Active-high segment pattern per digit
  always_comb begin
    case (digit_i)
      4'h0: seg_o = 7'h3f;
      4'h1: seg_o = 7'h06;
      4'h2: seg_o = 7'h5b;
      4'h3: seg_o = 7'h4f;
      4'h4: seg_o = 7'h66;
      4'h5: seg_o = 7'h6d;
      4'h6: seg_o = 7'h7d;
      4'h7: seg_o = 7'h07;
      4'h8: seg_o = 7'h7f;
      4'h9: seg_o = 7'h6f;
      4'ha: seg_o = 7'h77;
      4'hb: seg_o = 7'h7c;
      4'hc: seg_o = 7'h39;
      4'hd: seg_o = 7'h5e;
      4'he: seg_o = 7'h79;
      default: seg_o = 7'h71;
    endcase
  end
endmodule // mcx_seg_decode

//--- core/mcx_top.sv
/*
  Configuration check, fault shutdown and lamp drive of the muting controller,
  with an Avalon-MM register slave and one level interrupt.
  Assumes the muting sequencer supplies muting-active, waiting-for-acknowledge
  and the two raw safe switch requests, and that all inputs are synchronous.
*/
// Summary of operation
// - Reset-wait lamp lights exactly while the system waits for acknowledgment.
// - Both muting lamp outputs are high together while muting is active and no fault is set.
// - A high sensor input means a good muting detection.
// - Configuration comes from two eight-switch banks, each a full copy.
// - Only operating mode 7 is accepted for operation.
// - Switch 1 picks 2/4 sensors, switch 2 timing/sequence; 4 and sequence refused.
// - Switch 4 picks automatic or manual restart source.
// - Switches 3, 5, 6 enable feedback check, muting-enable, timeout extension.
// - A switch change during operation raises an error and drops both safe outputs.
// - After start-up the display shows 7 in operating mode 7 and an error glyph otherwise.
// - Differing switch banks raise an error and drop the safe outputs.
// - A start-up setting outside the permitted mode raises a mode error and drops outputs.
module mcx_top (
  input  wire logic                   CLK_SYS_I,
  input  wire logic                   RST_B_I,
  input  wire logic [4:0]             AVS_ADDRESS_I,
  input  wire logic                   AVS_READ_I,
  input  wire logic                   AVS_WRITE_I,
  input  wire logic [31:0]            AVS_WRITEDATA_I,
  input  wire logic [3:0]             AVS_BYTEENABLE_I,
  output logic      [31:0]            AVS_READDATA_O,
  output logic                        AVS_WAITREQUEST_O,
  input  wire mcx_pkg::mcx_cfg_t      BANK_A_I,
  input  wire mcx_pkg::mcx_cfg_t      BANK_B_I,
  input  wire logic [3:0]             MUTE_SENSOR_INPUT_I,
  input  wire logic                   MUTE_ACTIVE_I,
  input  wire logic                   RESET_WAIT_I,
  input  wire logic [1:0]             SAFE_REQ_I,
  output logic                        RESET_WAIT_LAMP_O,
  output logic [1:0]                  MUTE_LAMP_SOCKET_O,
  output logic [1:0]                  SAFE_SWITCH_OUTPUTS_O,
  output logic                        FAULT_O,
  output logic [3:0]                  MUTE_SENSOR_GOOD_O,
  output mcx_pkg::mcx_cfg_t           CFG_O,
  output logic [6:0]                  SEG_O,
  output logic                        IRQ_O
);
  import mcx_pkg::*;

  // State
  mcx_cfg_t             snap_ff;
  logic                 snap_vld_ff;
  logic                 fault_ff;
  logic [MCX_ST_W-1:0]  status_ff;
  logic [MCX_ST_W-1:0]  mask_ff;
  logic                 wait_ff;
  logic [31:0]          rdata_ff;
  logic [3:0]           sens_ff;
  logic                 rwl_ff;
  logic [1:0]           mlamp_ff;
  logic [1:0]           safe_ff;
  logic [6:0]           seg_ff;
  logic                 irq_ff;

  // Next values
  mcx_cfg_t             nxt_snap;
  logic                 nxt_fault;
  logic [MCX_ST_W-1:0]  nxt_status;
  logic [MCX_ST_W-1:0]  nxt_mask;
  logic [31:0]          nxt_rdata;

  // Error detection; checks start only once the snapshot is held
  // The mode check looks at the snapshot, not the live banks, so a mode error
  // only goes away with a new start-up; live edits of bank A show up as change errors.
  mcx_err_t err;
  wire      any_err;
  assign err.bank   = snap_vld_ff && (BANK_A_I != BANK_B_I);
  assign err.change = snap_vld_ff && (BANK_A_I != snap_ff);
  assign err.mode   = snap_vld_ff && (snap_ff[5:0] != MCX_MODE7_PAT);
  assign any_err    = err.bank || err.change || err.mode;

  // Bus decode; a request is taken on the edge where waitrequest is low
  wire req      = AVS_READ_I || AVS_WRITE_I;
  wire accept   = req && !wait_ff;
  wire wr_acc   = accept && AVS_WRITE_I && AVS_BYTEENABLE_I[0];
  wire sel_st   = (AVS_ADDRESS_I == MCX_OFF_STATUS);
  wire sel_mask = (AVS_ADDRESS_I == MCX_OFF_MASK);
  wire sel_cfg  = (AVS_ADDRESS_I == MCX_OFF_CFG);
  wire sel_live = (AVS_ADDRESS_I == MCX_OFF_LIVE);
  wire sel_ctrl = (AVS_ADDRESS_I == MCX_OFF_CTRL);
  wire [MCX_ST_W-1:0] st_clr = (wr_acc && sel_st) ? AVS_WRITEDATA_I[MCX_ST_W-1:0]
                                                  : {MCX_ST_W{1'b0}};
  wire fault_rel = wr_acc && sel_ctrl && AVS_WRITEDATA_I[MCX_CTRL_CLR];
  wire [MCX_ST_W-1:0] st_set = {err.mode, err.bank, err.change};

  // Sticky status: an event in the clear cycle survives
  assign nxt_status = (status_ff & ~st_clr) | st_set;
  assign nxt_mask   = (wr_acc && sel_mask) ? AVS_WRITEDATA_I[MCX_ST_W-1:0] : mask_ff;
  // Fault holds until software asks for release with every error gone
  assign nxt_fault  = any_err || (fault_ff && !fault_rel);
  // First cycle after release captures bank A, later it is kept
  assign nxt_snap   = snap_vld_ff ? snap_ff : BANK_A_I;

  // Read mux; unmapped offsets read as zero
  assign nxt_rdata =
      sel_st   ? {29'h0, status_ff} :
      sel_mask ? {29'h0, mask_ff} :
      sel_cfg  ? {23'h0, snap_vld_ff, snap_ff} :
      sel_live ? {8'h0, sens_ff, 3'h0, fault_ff, BANK_B_I, BANK_A_I} :
                 32'h0;

  // Display digit: mode number when permitted, error glyph otherwise
  wire [3:0] digit = (snap_ff[5:0] == MCX_MODE7_PAT) ? MCX_DIGIT_MODE7 : MCX_DIGIT_ERR;
  wire [6:0] seg_val;

  mcx_seg_decode u_seg (
    .digit_i (digit),
    .seg_o   (seg_val)
  );

  // Configuration snapshot and fault latch
  // Fault comes up in reset and clears as the snapshot is taken; snap_vld_ff keeps the
  // safe outputs off until the first comparison of the banks has been made.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      snap_ff     <= MCX_SNAP_RST;
      snap_vld_ff <= 1'b0;
      fault_ff    <= 1'b1;  // Held until the snapshot is taken, one cycle before the check
    end else begin
      snap_ff     <= nxt_snap;
      snap_vld_ff <= 1'b1;
      fault_ff    <= snap_vld_ff ? nxt_fault : 1'b0;
    end
  end

  // Status, mask and interrupt
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      status_ff <= MCX_STATUS_RST;
      mask_ff   <= MCX_MASK_RST;
      irq_ff    <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      mask_ff   <= nxt_mask;
      irq_ff    <= |(nxt_status & nxt_mask);
    end
  end

  // Bus handshake: one wait cycle, then the request is taken
  // Read data are fetched in the wait cycle so they already stand when the
  // master samples waitrequest low; the price is one extra cycle per access.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0;
    end else begin
      wait_ff  <= !(req && wait_ff);
      rdata_ff <= (req && wait_ff && AVS_READ_I) ? nxt_rdata : rdata_ff;
    end
  end

  // Pin side outputs, all gated by the fault latch where safety matters
  // Muting lamps and safe outputs use the next fault value so that they drop in the
  // same cycle as the fault latch rises, not one cycle after it.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      sens_ff  <= 4'h0;
      rwl_ff   <= 1'b0;
      mlamp_ff <= 2'h0;
      safe_ff  <= 2'h0;
      seg_ff   <= MCX_SEG_BLANK;
    end else begin
      sens_ff  <= MUTE_SENSOR_INPUT_I;
      rwl_ff   <= RESET_WAIT_I;
      mlamp_ff <= {2{MUTE_ACTIVE_I && !nxt_fault}};
      safe_ff  <= (snap_vld_ff && !nxt_fault) ? SAFE_REQ_I : 2'h0;
      seg_ff   <= snap_vld_ff ? seg_val : MCX_SEG_BLANK;
    end
  end

  assign AVS_READDATA_O        = rdata_ff;
  assign AVS_WAITREQUEST_O     = wait_ff;
  assign RESET_WAIT_LAMP_O     = rwl_ff;
  assign MUTE_LAMP_SOCKET_O    = mlamp_ff;
  assign SAFE_SWITCH_OUTPUTS_O = safe_ff;
  assign FAULT_O               = fault_ff;
  assign MUTE_SENSOR_GOOD_O    = sens_ff;
  // Decoded fields straight from the snapshot register for the sequencer
  assign CFG_O                 = snap_ff;
  assign SEG_O                 = seg_ff;
  assign IRQ_O                 = irq_ff;

  // Checks on the block's own outputs
  chk_lamp_follows: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    $past(RST_B_I) |-> RESET_WAIT_LAMP_O == $past(RESET_WAIT_I))
    else $error("reset-wait lamp not following wait state");

  chk_mute_lamp_pair: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    MUTE_LAMP_SOCKET_O[0] == MUTE_LAMP_SOCKET_O[1])
    else $error("muting lamp outputs differ");

  chk_mute_lamp_on: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (MUTE_ACTIVE_I && !nxt_fault) |=> MUTE_LAMP_SOCKET_O == 2'h3)
    else $error("muting lamp not lit while muting");

  chk_sensor_level: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    $past(RST_B_I) |-> MUTE_SENSOR_GOOD_O == $past(MUTE_SENSOR_INPUT_I))
    else $error("sensor level not reported");

  chk_bank_shutdown: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (snap_vld_ff && BANK_A_I != BANK_B_I) |=> SAFE_SWITCH_OUTPUTS_O == 2'h0 && FAULT_O)
    else $error("bank mismatch did not shut down");

  chk_change_shutdown: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (snap_vld_ff && BANK_A_I != snap_ff) |=> SAFE_SWITCH_OUTPUTS_O == 2'h0 ##0 status_ff[MCX_ST_CHANGE])
    else $error("switch change did not shut down");

  chk_mode_only7: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (SAFE_SWITCH_OUTPUTS_O != 2'h0) |-> CFG_O[5:0] == MCX_MODE7_PAT)
    else $error("safe outputs on outside mode 7");

  chk_snapshot_hold: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    snap_vld_ff |=> $stable(snap_ff))
    else $error("snapshot moved after start-up");

  chk_display_mode: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (snap_vld_ff && snap_ff[5:0] == MCX_MODE7_PAT) |=> SEG_O == 7'h07)
    else $error("display not showing mode 7");

  chk_bus_answer: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (req && wait_ff) |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
    else $error("bus answer not one wait cycle");

  // Shutdown, start-up, status, lamp and bus checks
  chk_fault_off: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    FAULT_O |-> SAFE_SWITCH_OUTPUTS_O == 2'h0)
    else $error("safe outputs on while faulted");

  chk_mode_fault: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    err.mode |=> FAULT_O && status_ff[MCX_ST_MODE])
    else $error("mode error did not fault");

  chk_release_held: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (fault_rel && any_err) |=> FAULT_O)
    else $error("fault released with an error present");

  chk_display_err: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (snap_vld_ff && snap_ff[5:0] != MCX_MODE7_PAT) |=> SEG_O == 7'h79)
    else $error("display not showing the error glyph");

  chk_snapshot_take: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (RST_B_I && !snap_vld_ff) |=> snap_vld_ff && !FAULT_O && CFG_O == $past(BANK_A_I))
    else $error("snapshot not taken at start-up");

  chk_seg_blank: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (RST_B_I && !snap_vld_ff) |=> SEG_O == MCX_SEG_BLANK)
    else $error("display not blank before the snapshot");

  chk_safe_follows: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (snap_vld_ff && !nxt_fault) |=> SAFE_SWITCH_OUTPUTS_O == $past(SAFE_REQ_I))
    else $error("safe outputs not following request");

  chk_mute_lamp_off: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    !MUTE_ACTIVE_I |=> MUTE_LAMP_SOCKET_O == 2'h0)
    else $error("muting lamp lit without muting");

  chk_rwl_off: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    !RESET_WAIT_I |=> !RESET_WAIT_LAMP_O)
    else $error("reset-wait lamp lit while not waiting");

  chk_bank_status: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    err.bank |=> status_ff[MCX_ST_BANK])
    else $error("bank mismatch not flagged");

  chk_change_sticky: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (status_ff[MCX_ST_CHANGE] && !st_clr[MCX_ST_CHANGE]) |=> status_ff[MCX_ST_CHANGE])
    else $error("change flag lost without a clear");

  chk_irq_level: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    IRQ_O == |(status_ff & mask_ff))
    else $error("interrupt not matching masked status");

  chk_mask_write: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (wr_acc && sel_mask) |=> mask_ff == $past(AVS_WRITEDATA_I[MCX_ST_W-1:0]))
    else $error("mask write not stored");

  chk_bus_idle: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    !req |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low without a request");

  chk_read_unmapped: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (req && wait_ff && AVS_READ_I && !(sel_st || sel_mask || sel_cfg || sel_live)) |=>
    AVS_READDATA_O == 32'h0)
    else $error("unmapped read not zero");

  cov_good_run: cover property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    SAFE_SWITCH_OUTPUTS_O == 2'h3 && MUTE_LAMP_SOCKET_O == 2'h3);
  cov_change_fault: cover property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    !FAULT_O ##1 err.change ##1 FAULT_O);
  cov_fault_release: cover property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    FAULT_O ##1 !FAULT_O);
  cov_irq: cover property (@(posedge CLK_SYS_I) disable iff (!RST_B_I) $rose(IRQ_O));
  cov_mode_error: cover property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    err.mode ##1 SEG_O == 7'h79);
endmodule // mcx_top

//--- tb/mcx_far_model.sv
/*
  Far-side model: the four muting sensors and the external muting lamp.
  Assumes the bench says which sensors see a valid object each cycle.
*/
module mcx_far_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] detect_i,
  input  wire logic [1:0] lamp_i,
  output logic      [3:0] sensor_o,
  output logic            lamp_err_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // A sensor drives its line high while it sees a valid object
  assign sensor_o = detect_i;

  logic split_seen = 1'b0;

  // Lamp wires must always agree; a split lamp is latched as an error
  always @(posedge clk_i) begin
    if (lamp_i[0] !== lamp_i[1]) split_seen <= 1'b1;
  end

  assign lamp_err_o = split_seen;
endmodule // mcx_far_model

//--- tb/tb.sv
/*
  Self-checking bench for the configuration check and lamp block.
  Assumes the block answers bus requests with waitrequest and one clock.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mcx_pkg::*;

  logic clk, rst_b, rd, wr, mute, rwait, irq, fault, rwl, lerr;
  logic [4:0] adr;
  logic [31:0] wd, rdat, q;
  logic [1:0] req, lamp, safe;
  logic [3:0] det, sens, good;
  logic [6:0] seg;
  logic waitreq;
  mcx_cfg_t bank_a, bank_b, cfg;
  int mismatches, comparisons;

  mcx_top dut (.CLK_SYS_I(clk), .RST_B_I(rst_b), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hf),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(waitreq), .BANK_A_I(bank_a),
    .BANK_B_I(bank_b), .MUTE_SENSOR_INPUT_I(sens), .MUTE_ACTIVE_I(mute),
    .RESET_WAIT_I(rwait), .SAFE_REQ_I(req), .RESET_WAIT_LAMP_O(rwl),
    .MUTE_LAMP_SOCKET_O(lamp), .SAFE_SWITCH_OUTPUTS_O(safe), .FAULT_O(fault),
    .MUTE_SENSOR_GOOD_O(good), .CFG_O(cfg), .SEG_O(seg), .IRQ_O(irq));

  mcx_far_model far (.clk_i(clk), .detect_i(det), .lamp_i(lamp), .sensor_o(sens),
    .lamp_err_o(lerr));

  // Free-running 10 MHz system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic wrap_up();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // One bus cycle; held until waitrequest is sampled low, read data taken there
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      wrap_up();
    end
  endtask

  // Lets a few edges land, then samples away from the edge
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  // Power-up with both banks set alike; fault must hold during reset
  task automatic power_up(input logic [7:0] v);
    @(posedge clk);
    rst_b <= 1'b0;
    bank_a <= v;
    bank_b <= v;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk(fault, 1'b1);
    chk(safe, 2'h0);
    @(posedge clk);
    rst_b <= 1'b1;
    settle();
  endtask

  // Valid mode 7 with timeout switches 7/8 on: accepted and displayed
  task automatic sc_start();
    power_up(8'hd8);
    chk(cfg, 8'hd8);
    chk(seg, 7'h07);
    chk(safe, 2'h3);
    bus(1'b0, MCX_OFF_CFG, 32'h0);
    chk(q, 32'h1d8);
    bus(1'b0, 5'h14, 32'h0);
    chk(q, 32'h0);
  endtask

  // Lamps and sensors follow their sources one cycle late
  task automatic sc_lamps();
    @(posedge clk);
    rwait <= 1'b1;
    mute <= 1'b1;
    det <= 4'ha;
    @(posedge clk);
    @(negedge clk);
    chk(rwl, 1'b1);
    chk(lamp, 2'h3);
    chk(good, 4'ha);
    @(posedge clk);
    rwait <= 1'b0;
    mute <= 1'b0;
    det <= 4'h5;
    @(posedge clk);
    @(negedge clk);
    chk(rwl, 1'b0);
    chk(lamp, 2'h0);
    chk(good, 4'h5);
    chk(lerr, 1'b0);
  endtask

  // Banks differ: fault, interrupt through the mask, then clear and release
  task automatic sc_bank();
    bus(1'b1, MCX_OFF_MASK, 32'h2);
    bank_b <= 8'hd9;
    mute <= 1'b1;
    settle();
    chk(fault, 1'b1);
    chk(safe, 2'h0);
    chk(irq, 1'b1);
    chk(lamp, 2'h0);
    bus(1'b0, MCX_OFF_LIVE, 32'h0);
    chk(q[16:0], 17'h1d9d8);
    bank_b <= 8'hd8;
    bus(1'b1, MCX_OFF_STATUS, 32'h7);
    bus(1'b1, MCX_OFF_CTRL, 32'h1);
    settle();
    chk({irq, fault, safe}, 4'h3);
    chk(lamp, 2'h3);
  endtask

  // Both banks changed alike while running: change error only
  task automatic sc_change();
    @(posedge clk);
    bank_a <= 8'hdc;
    bank_b <= 8'hdc;
    settle();
    chk(fault, 1'b1);
    chk(safe, 2'h0);
    chk(lamp, 2'h0);
    bus(1'b0, MCX_OFF_STATUS, 32'h0);
    chk(q[2:0], 3'h1);
    bank_a <= 8'hd8;
    bank_b <= 8'hd8;
    bus(1'b1, MCX_OFF_STATUS, 32'h7);
    bus(1'b1, MCX_OFF_CTRL, 32'h1);
    settle();
    chk(fault, 1'b0);
  endtask

  // Each of switches 1..6 flipped from mode 7 at power-up is refused
  task automatic sc_modes();
    for (int i = 0; i < 6; i++) begin
      power_up(8'hd8 ^ (8'h01 << i));
      chk(seg, 7'h79);
      chk(cfg, 8'hd8 ^ (8'h01 << i));
      chk({fault, safe}, 3'h4);
      bus(1'b0, MCX_OFF_STATUS, 32'h0);
      chk(q[2], 1'b1);
    end
  endtask

  // Main sequence
  initial begin
    mismatches = 0;
    comparisons = 0;
    {rst_b, rd, wr, mute, rwait} = 5'h0;
    adr = 5'h00;
    wd = 32'h0;
    req = 2'h3;
    det = 4'h0;
    bank_a = 8'hd8;
    bank_b = 8'hd8;
    sc_start();
    sc_lamps();
    sc_bank();
    sc_change();
    sc_modes();
    wrap_up();
  end
endmodule // tb
